// [hw/syn_serial_port.sv]
// synchronous serial port master with status, clear, dma enable and prescaler
module syn_serial_port (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic serial_data_in_i,
	output logic serial_data_out_o,
	output logic serial_bit_clock_o,
	output logic serial_frame_o,
	output logic tx_dma_req_o,
	output logic rx_dma_req_o,
	output logic combined_port_interrupt_o
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic wait_r;
	logic [31:0] rdata_r;
	logic [31:0] rd_val;
	logic wr_acc;
	logic rd_acc;
	logic [3:0] size_r;
	logic [1:0] fmt_r;
	logic [7:0] rate_r;
	logic enable_r;
	logic [6:0] prescale_r;
	logic [3:0] imask_r;
	logic [1:0] dma_en_r;
	logic din_meta_r;
	logic din_sync_r;
	logic [6:0] pre_cnt_r;
	logic [6:0] pre_last;
	logic [7:0] post_cnt_r;
	logic pre_tick;
	logic edge_tick;
	logic phase_r;
	logic bit_tick;
	syn_pkg::syn_state_t state_r;
	logic sclk_r;
	logic frame_r;
	logic sync_cnt_r;
	logic [4:0] bit_cnt_r;
	logic [4:0] size_bits;
	logic [15:0] tx_shift_r;
	logic [15:0] rx_shift_r;
	logic start;
	logic frame_done;
	logic frame_idle;
	logic busy;
	logic tx_push;
	logic rx_pop;
	logic [15:0] tx_head;
	logic [15:0] rx_head;
	logic [3:0] tx_count;
	logic [3:0] rx_count;
	logic tx_full;
	logic tx_empty;
	logic rx_full;
	logic rx_empty;
	logic [5:0] idle_cnt_r;
	logic to_flag_r;
	logic ovr_flag_r;
	logic to_set;
	logic ovr_set;
	logic to_clr;
	logic ovr_clr;
	logic [3:0] raw;
	logic [3:0] masked;
	logic irq_r;
	logic tx_dma_r;
	logic rx_dma_r;

	assign avs_waitrequest_o = wait_r;
	assign avs_readdata_o = rdata_r;
	assign serial_data_out_o = tx_shift_r[15];
	assign serial_bit_clock_o = sclk_r;
	assign serial_frame_o = frame_r;
	assign tx_dma_req_o = tx_dma_r;
	assign rx_dma_req_o = rx_dma_r;
	assign combined_port_interrupt_o = irq_r;

	// ----------------------------------------------------------------
	// bus slave: one wait state, then the request is taken
	// ----------------------------------------------------------------
	assign wr_acc = avs_write_i && !wait_r;
	assign rd_acc = avs_read_i && !wait_r;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wait_r <= 1'b1;
		end else if ((avs_read_i || avs_write_i) && wait_r) begin
			wait_r <= 1'b0;
		end else begin
			wait_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_r <= 32'h0000_0000;
		end else if (avs_read_i && wait_r) begin
			rdata_r <= rd_val;
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		case (avs_address_i)
			syn_pkg::OFS_CR0: rd_val[15:0] = {rate_r, 2'h0, fmt_r, size_r};
			syn_pkg::OFS_CR1: rd_val[syn_pkg::BIT_ENABLE] = enable_r;
			syn_pkg::OFS_DATA: rd_val[15:0] = rx_head;
			syn_pkg::OFS_STAT: rd_val[4:0] = {busy, rx_full, !rx_empty, !tx_full, tx_empty};
			syn_pkg::OFS_PRESCALE: rd_val[7:0] = {prescale_r, 1'b0};
			syn_pkg::OFS_IMASK: rd_val[3:0] = imask_r;
			syn_pkg::OFS_RAW: rd_val[3:0] = raw;
			syn_pkg::OFS_MASKED: rd_val[3:0] = masked;
			syn_pkg::OFS_DMA: rd_val[1:0] = dma_en_r;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			size_r <= syn_pkg::SIZE_RST;
			fmt_r <= syn_pkg::FMT_RST;
			rate_r <= syn_pkg::RATE_RST;
			enable_r <= 1'b0;
		end else if (wr_acc) begin
			if (avs_address_i == syn_pkg::OFS_CR0 && avs_byteenable_i[0]) begin
				size_r <= avs_writedata_i[3:0];
				fmt_r <= avs_writedata_i[5:4];
			end
			if (avs_address_i == syn_pkg::OFS_CR0 && avs_byteenable_i[1]) begin
				rate_r <= avs_writedata_i[15:8];
			end
			if (avs_address_i == syn_pkg::OFS_CR1 && avs_byteenable_i[0]) begin
				enable_r <= avs_writedata_i[syn_pkg::BIT_ENABLE];
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prescale_r <= syn_pkg::PRESCALE_RST;
			imask_r <= syn_pkg::IMASK_RST;
			dma_en_r <= syn_pkg::DMA_RST;
		end else if (wr_acc && avs_byteenable_i[0]) begin
			if (avs_address_i == syn_pkg::OFS_PRESCALE) begin
				prescale_r <= avs_writedata_i[7:1];
			end
			if (avs_address_i == syn_pkg::OFS_IMASK) begin
				imask_r <= avs_writedata_i[3:0];
			end
			if (avs_address_i == syn_pkg::OFS_DMA) begin
				dma_en_r <= avs_writedata_i[1:0];
			end
		end
	end

	assign tx_push = wr_acc && avs_address_i == syn_pkg::OFS_DATA && avs_byteenable_i[0];
	assign rx_pop = rd_acc && avs_address_i == syn_pkg::OFS_DATA;
	assign to_clr = wr_acc && avs_address_i == syn_pkg::OFS_ICLR && avs_byteenable_i[0]
		&& avs_writedata_i[syn_pkg::BIT_TO];
	assign ovr_clr = wr_acc && avs_address_i == syn_pkg::OFS_ICLR && avs_byteenable_i[0]
		&& avs_writedata_i[syn_pkg::BIT_OVR];

	// ----------------------------------------------------------------
	// fifos
	// ----------------------------------------------------------------
	syn_fifo u_tx_fifo (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.push_i(tx_push),
		.wdata_i(avs_writedata_i[15:0]),
		.pop_i(start),
		.rdata_o(tx_head),
		.count_o(tx_count),
		.full_o(tx_full),
		.empty_o(tx_empty)
	);

	syn_fifo u_rx_fifo (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.push_i(frame_done),
		.wdata_i(rx_shift_r),
		.pop_i(rx_pop),
		.rdata_o(rx_head),
		.count_o(rx_count),
		.full_o(rx_full),
		.empty_o(rx_empty)
	);

	// ----------------------------------------------------------------
	// clock divider
	// ----------------------------------------------------------------
	// the first stage counts half the even divisor and the clock toggles,
	// so each edge lands mid-period; divisors below two act as two
	assign pre_last = (prescale_r == 7'h00) ? 7'h00 : 7'(prescale_r - 7'h01);
	assign pre_tick = (pre_cnt_r == pre_last);
	assign edge_tick = pre_tick && (post_cnt_r == rate_r);
	assign bit_tick = edge_tick && phase_r;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pre_cnt_r <= 7'h00;
			post_cnt_r <= 8'h00;
			phase_r <= 1'b0;
		end else begin
			pre_cnt_r <= pre_tick ? 7'h00 : 7'(pre_cnt_r + 7'h01);
			if (edge_tick) begin
				post_cnt_r <= 8'h00;
			end else if (pre_tick) begin
				post_cnt_r <= 8'(post_cnt_r + 8'h01);
			end
			// two edges per bit: period is divisor times rate plus one
			if (edge_tick) begin
				phase_r <= !phase_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// shift engine
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			din_meta_r <= 1'b0;
			din_sync_r <= 1'b0;
		end else begin
			din_meta_r <= serial_data_in_i;
			din_sync_r <= din_meta_r;
		end
	end

	assign size_bits = (size_r < syn_pkg::MIN_SIZE_CODE) ? syn_pkg::MIN_BITS
		: 5'({1'b0, size_r} + 5'h01);
	assign frame_idle = (fmt_r != syn_pkg::FMT_SSI);
	assign start = state_r == syn_pkg::ST_IDLE && enable_r && !tx_empty && edge_tick;
	assign frame_done = state_r == syn_pkg::ST_SHIFT && enable_r && edge_tick && sclk_r
		&& bit_cnt_r == size_bits;
	assign busy = (state_r != syn_pkg::ST_IDLE) || !tx_empty;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= syn_pkg::ST_IDLE;
			sclk_r <= 1'b0;
			frame_r <= 1'b1;
			sync_cnt_r <= 1'b0;
			bit_cnt_r <= 5'h00;
			tx_shift_r <= 16'h0000;
			rx_shift_r <= 16'h0000;
		end else if (!enable_r) begin
			// disabling mid-word abandons it; the partial word is dropped
			state_r <= syn_pkg::ST_IDLE;
			sclk_r <= 1'b0;
			frame_r <= frame_idle;
		end else begin
			case (state_r)
				syn_pkg::ST_IDLE: begin
					frame_r <= frame_idle;
					if (start) begin
						tx_shift_r <= 16'(tx_head << (syn_pkg::DATA_BITS - size_bits));
						rx_shift_r <= 16'h0000;
						bit_cnt_r <= 5'h00;
						sync_cnt_r <= 1'b0;
						frame_r <= !frame_idle;
						state_r <= (fmt_r == syn_pkg::FMT_SSI) ? syn_pkg::ST_SYNC
							: syn_pkg::ST_SHIFT;
					end
				end
				syn_pkg::ST_SYNC: begin
					if (edge_tick) begin
						sync_cnt_r <= 1'b1;
						if (sync_cnt_r) begin
							frame_r <= 1'b0;
							state_r <= syn_pkg::ST_SHIFT;
						end
					end
				end
				syn_pkg::ST_SHIFT: begin
					if (edge_tick && !sclk_r) begin
						sclk_r <= 1'b1;
						rx_shift_r <= {rx_shift_r[14:0], din_sync_r};
						bit_cnt_r <= 5'(bit_cnt_r + 5'h01);
					end else if (edge_tick) begin
						sclk_r <= 1'b0;
						if (bit_cnt_r == size_bits) begin
							frame_r <= frame_idle;
							state_r <= syn_pkg::ST_IDLE;
						end else begin
							tx_shift_r <= {tx_shift_r[14:0], 1'b0};
						end
					end
				end
				default: state_r <= syn_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	// reading data restarts the idle window, so only unserviced data times out
	assign to_set = !rx_empty && state_r == syn_pkg::ST_IDLE && !start && bit_tick
		&& idle_cnt_r == 6'(syn_pkg::IDLE_BITS - 6'h01);
	assign ovr_set = frame_done && rx_full && !rx_pop;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			idle_cnt_r <= 6'h00;
		end else if (start || rx_empty || rx_pop || to_clr) begin
			idle_cnt_r <= 6'h00;
		end else if (state_r == syn_pkg::ST_IDLE && bit_tick
			&& idle_cnt_r != syn_pkg::IDLE_BITS) begin
			idle_cnt_r <= 6'(idle_cnt_r + 6'h01);
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			to_flag_r <= 1'b0;
		end else if (to_set) begin
			to_flag_r <= 1'b1;
		end else if (start || to_clr) begin
			to_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ovr_flag_r <= 1'b0;
		end else if (ovr_set) begin
			ovr_flag_r <= 1'b1;
		end else if (ovr_clr) begin
			ovr_flag_r <= 1'b0;
		end
	end

	assign raw[syn_pkg::BIT_TX] = (tx_count <= syn_pkg::TX_LOW_MARK) || !enable_r;
	assign raw[syn_pkg::BIT_RX] = (rx_count >= syn_pkg::RX_HIGH_MARK);
	assign raw[syn_pkg::BIT_TO] = to_flag_r;
	assign raw[syn_pkg::BIT_OVR] = ovr_flag_r;
	assign masked = raw & imask_r;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_r <= 1'b0;
			tx_dma_r <= 1'b0;
			rx_dma_r <= 1'b0;
		end else begin
			irq_r <= |masked;
			tx_dma_r <= dma_en_r[syn_pkg::BIT_TX_DMA] && enable_r
				&& tx_count <= syn_pkg::TX_LOW_MARK;
			rx_dma_r <= dma_en_r[syn_pkg::BIT_RX_DMA] && enable_r
				&& rx_count >= syn_pkg::RX_HIGH_MARK;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	AST_RAW_READ: assert property (
		(avs_read_i && wait_r && avs_address_i == syn_pkg::OFS_RAW)
		|=> avs_readdata_o[3:0] == $past(raw))
		else $error("raw status read mismatch");
	AST_MASKED_READ: assert property (
		(avs_read_i && wait_r && avs_address_i == syn_pkg::OFS_MASKED)
		|=> avs_readdata_o[3:0] == ($past(raw) & $past(imask_r)))
		else $error("masked status read mismatch");
	AST_MASK_OFF: assert property (
		imask_r == 4'h0 |-> masked == 4'h0)
		else $error("masked flag set with enables off");
	AST_TO_CLEAR: assert property (
		(to_clr && !to_set) |=> !to_flag_r)
		else $error("time-out flag not cleared");
	AST_OVR_KEEP: assert property (
		(ovr_flag_r && !ovr_clr) |=> ovr_flag_r)
		else $error("overrun flag lost without clear");
	AST_DMA_WRITE: assert property (
		(wr_acc && avs_byteenable_i[0] && avs_address_i == syn_pkg::OFS_DMA)
		|=> dma_en_r == $past(avs_writedata_i[1:0]))
		else $error("dma enable write not stored");
	AST_ODD_IGNORED: assert property (
		(!avs_waitrequest_o && avs_read_i && avs_address_i == syn_pkg::OFS_PRESCALE)
		|-> !avs_readdata_o[0])
		else $error("prescale low bit reads one");
	AST_CLOCK_EDGE: assert property (
		$changed(sclk_r) && $past(enable_r) |-> $past(edge_tick))
		else $error("serial clock moved off divider edge");
	AST_IRQ_OR: assert property (
		(|masked) |=> combined_port_interrupt_o)
		else $error("interrupt output missed a source");
	AST_TX_DISABLED: assert property (
		!enable_r |-> raw[syn_pkg::BIT_TX])
		else $error("transmit flag low while disabled");
	AST_TO_SET: assert property (
		to_set |=> to_flag_r)
		else $error("time-out flag not raised");

	COV_WORD: cover property (frame_done);
	COV_TIMEOUT: cover property ($rose(to_flag_r));
	COV_OVERRUN: cover property ($rose(ovr_flag_r));
	COV_IRQ: cover property ($rose(combined_port_interrupt_o));
endmodule

// [hw/syn_pkg.sv]
// constants and types shared by the synchronous serial port design
package syn_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int PTR_W = 3;
	localparam int CNT_W = 4;
	localparam logic [4:0] DATA_BITS = 5'h10;
	localparam logic [3:0] MIN_SIZE_CODE = 4'h3;
	localparam logic [4:0] MIN_BITS = 5'h04;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [5:0] OFS_CR0 = 6'h00;
	localparam logic [5:0] OFS_CR1 = 6'h04;
	localparam logic [5:0] OFS_DATA = 6'h08;
	localparam logic [5:0] OFS_STAT = 6'h0C;
	localparam logic [5:0] OFS_PRESCALE = 6'h10;
	localparam logic [5:0] OFS_IMASK = 6'h14;
	localparam logic [5:0] OFS_RAW = 6'h18;
	localparam logic [5:0] OFS_MASKED = 6'h1C;
	localparam logic [5:0] OFS_ICLR = 6'h20;
	localparam logic [5:0] OFS_DMA = 6'h24;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_TX = 3;
	localparam int BIT_RX = 2;
	localparam int BIT_TO = 1;
	localparam int BIT_OVR = 0;
	localparam int BIT_TX_DMA = 1;
	localparam int BIT_RX_DMA = 0;
	localparam int BIT_ENABLE = 1;

	// ----------------------------------------------------------------
	// reset values, encodings and counts
	// ----------------------------------------------------------------
	localparam logic [3:0] SIZE_RST = 4'h0;
	localparam logic [1:0] FMT_RST = 2'h0;
	localparam logic [7:0] RATE_RST = 8'h00;
	localparam logic [6:0] PRESCALE_RST = 7'h00;
	localparam logic [3:0] IMASK_RST = 4'h0;
	localparam logic [1:0] DMA_RST = 2'h0;
	localparam logic [1:0] FMT_SPI = 2'h0;
	localparam logic [1:0] FMT_SSI = 2'h1;
	localparam logic [1:0] FMT_MW = 2'h2;
	localparam logic [3:0] TX_LOW_MARK = 4'h4;
	localparam logic [3:0] RX_HIGH_MARK = 4'h4;
	localparam logic [5:0] IDLE_BITS = 6'h20;

	typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_SHIFT} syn_state_t;
endpackage

// [hw/syn_fifo.sv]
// eight-entry word fifo with registered head data
module syn_fifo (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic push_i,
	input wire logic [15:0] wdata_i,
	input wire logic pop_i,
	output logic [15:0] rdata_o,
	output logic [3:0] count_o,
	output logic full_o,
	output logic empty_o
);
	logic [15:0] mem_r [syn_pkg::FIFO_DEPTH];
	logic [2:0] wr_ptr_r;
	logic [2:0] rd_ptr_r;
	logic [2:0] rd_nxt;
	logic [3:0] count_r;
	logic [15:0] head_r;
	logic do_push;
	logic do_pop;

	assign empty_o = (count_r == 4'h0);
	assign full_o = (count_r == 4'(syn_pkg::FIFO_DEPTH));
	assign count_o = count_r;
	assign rdata_o = head_r;
	assign do_pop = pop_i && !empty_o;
	// a full fifo still takes a word when one leaves in the same cycle
	assign do_push = push_i && (!full_o || do_pop);
	assign rd_nxt = do_pop ? 3'(rd_ptr_r + 3'h1) : rd_ptr_r;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	for (genvar i = 0; i < syn_pkg::FIFO_DEPTH; i++) begin : g_entry
		always_ff @(posedge clk_i) begin
			if (do_push && wr_ptr_r == 3'(i)) begin
				mem_r[i] <= wdata_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// pointers and head register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ptr_r <= 3'h0;
			rd_ptr_r <= 3'h0;
			count_r <= 4'h0;
			head_r <= 16'h0000;
		end else begin
			if (do_push) begin
				wr_ptr_r <= 3'(wr_ptr_r + 3'h1);
			end
			rd_ptr_r <= rd_nxt;
			count_r <= 4'(count_r + {3'h0, do_push} - {3'h0, do_pop});
			// the word being written becomes head when nothing older is left
			if (do_push && count_r == {3'h0, do_pop}) begin
				head_r <= wdata_i;
			end else begin
				head_r <= mem_r[rd_nxt];
			end
		end
	end
endmodule

// [sim/syn_peer.sv]
// behavioural serial peripheral that answers each word with the one it got before
module syn_peer (
	input wire logic clk_i,
	input wire logic sclk_i,
	input wire logic frame_i,
	input wire logic sdo_i,
	output logic sdi_o,
	output logic [15:0] got_o,
	output logic [7:0] words_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] sh = 16'h5A3C;
	logic [15:0] rx = 16'h5A3C;
	logic tog = 1'b0;
	initial got_o = 16'h5A3C;
	initial words_o = 8'h00;
	// released line wiggles every cycle so a late sample never sees a stale bit
	always @(posedge clk_i) tog <= ~tog;
	assign sdi_o = frame_i ? tog : sh[15];
	// one process for the shifter: reload on rising frame, shift on falling clock
	always @(posedge frame_i or negedge sclk_i) begin
		if (frame_i) sh <= rx;
		else sh <= {sh[14:0], 1'b0};
	end
	always @(posedge sclk_i) if (!frame_i) rx <= {rx[14:0], sdo_i};
	always @(posedge frame_i) begin
		got_o <= rx;
		words_o <= words_o + 8'h01;
	end
endmodule

// [sim/testbench.sv]
// self-checking bench for the synchronous serial port
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [5:0] avs_address_i = 6'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic sdi, sdo, sclk, frame, txdr, rxdr, irq;
	logic [15:0] got;
	logic [7:0] words;
	logic s_rd, s_wait;
	logic [31:0] s_data;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [15:0] tx_w[0:9];
	logic [15:0] per = 16'h0;
	logic [15:0] cnt = 16'h0;
	logic sclk_d = 1'b0;
	int miscompares = 0;
	int n_checks = 0;
	int seed = 58279;
	always #25 clk_i = ~clk_i;

	syn_serial_port dut (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.serial_data_in_i(sdi), .serial_data_out_o(sdo), .serial_bit_clock_o(sclk),
		.serial_frame_o(frame), .tx_dma_req_o(txdr), .rx_dma_req_o(rxdr),
		.combined_port_interrupt_o(irq));
	syn_peer peer (.clk_i(clk_i), .sclk_i(sclk), .frame_i(frame), .sdo_i(sdo), .sdi_o(sdi),
		.got_o(got), .words_o(words));

	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// bus master and monitor
	// ----------------------------------------------------------------
	// settled copies taken mid-cycle, so the rising edge never races the outputs
	always @(negedge clk_i) begin
		s_rd = avs_read_i;
		s_wait = avs_waitrequest_o;
		s_data = avs_readdata_o;
		cnt <= (sclk && !sclk_d) ? 16'h1 : cnt + 16'h1;
		if (sclk && !sclk_d) per <= cnt;
		sclk_d <= sclk;
	end
	always @(posedge clk_i) begin
		if (s_rd === 1'b1 && s_wait === 1'b0 && exp_q.size() > 0)
			chk("readdata", s_data & msk_q.pop_front(), exp_q.pop_front());
	end
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		if (wr) avs_write_i <= 1'b1;
		else avs_read_i <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_i);
			if (s_wait === 1'b0) break;
		end
		if (i == 50) begin
			miscompares++;
			close_out();
		end
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic wait_words(input logic [7:0] n);
		int i;
		for (i = 0; i < 5000 && words != n; i++) @(posedge clk_i);
		if (i == 5000) begin
			miscompares++;
			close_out();
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] w0;
		int k;
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'b1;
		rd(syn_pkg::OFS_RAW, 32'h8, 32'hF);
		rd(syn_pkg::OFS_MASKED, 32'h0, 32'hF);
		rd(syn_pkg::OFS_DMA, 32'h0, 32'h3);
		rd(6'h3C, 32'h0, 32'hFFFFFFFF);
		wr(syn_pkg::OFS_IMASK, 32'h8);
		rd(syn_pkg::OFS_MASKED, 32'h8, 32'hF);
		repeat (3) @(posedge clk_i);
		chk("irq", 32'(irq), 32'h1);
		wr(syn_pkg::OFS_IMASK, 32'h0);
		wr(syn_pkg::OFS_DMA, 32'h3);
		rd(syn_pkg::OFS_DMA, 32'h3, 32'h3);
		repeat (3) @(posedge clk_i);
		chk("irq", 32'(irq), 32'h0);
		$display("test registers done");
		// odd divisor must act as the even one below it
		wr(syn_pkg::OFS_PRESCALE, 32'h5);
		rd(syn_pkg::OFS_PRESCALE, 32'h4, 32'hFF);
		wr(syn_pkg::OFS_CR0, 32'h010F);
		wr(syn_pkg::OFS_CR1, 32'h2);
		rd(syn_pkg::OFS_RAW, 32'h8, 32'hF);
		chk("tx dma", 32'(txdr), 32'h1);
		tx_w[0] = 16'($random(seed));
		w0 = words;
		wr(syn_pkg::OFS_DATA, {16'h0, tx_w[0]});
		wait_words(w0 + 8'h1);
		chk("peer word", 32'(got), 32'(tx_w[0]));
		chk("bit period", 32'(per), 32'h8);
		rd(syn_pkg::OFS_DATA, 32'h5A3C, 32'hFFFF);
		$display("test one word done");
		for (k = 1; k <= 9; k++) begin
			tx_w[k] = 16'($random(seed));
			wr(syn_pkg::OFS_DATA, {16'h0, tx_w[k]});
		end
		wait_words(w0 + 8'hA);
		repeat (4) @(posedge clk_i);
		rd(syn_pkg::OFS_RAW, 32'hD, 32'hD);
		chk("rx dma", 32'(rxdr), 32'h1);
		repeat (300) @(posedge clk_i);
		rd(syn_pkg::OFS_RAW, 32'hF, 32'hF);
		wr(syn_pkg::OFS_IMASK, 32'h5);
		rd(syn_pkg::OFS_MASKED, 32'h5, 32'hF);
		wr(syn_pkg::OFS_ICLR, 32'h0);
		rd(syn_pkg::OFS_RAW, 32'hF, 32'hF);
		wr(syn_pkg::OFS_ICLR, 32'h2);
		rd(syn_pkg::OFS_RAW, 32'hD, 32'hF);
		wr(syn_pkg::OFS_ICLR, 32'h1);
		rd(syn_pkg::OFS_RAW, 32'hC, 32'hF);
		for (k = 0; k < 8; k++) rd(syn_pkg::OFS_DATA, 32'(tx_w[k]), 32'hFFFF);
		rd(syn_pkg::OFS_RAW, 32'h8, 32'hF);
		chk("rx dma", 32'(rxdr), 32'h0);
		repeat (3) @(posedge clk_i);
		chk("irq", 32'(irq), 32'h0);
		$display("test overrun and time-out done");
		// a disabled port flags transmit even with a well filled fifo
		wr(syn_pkg::OFS_CR1, 32'h0);
		for (k = 0; k < 6; k++) wr(syn_pkg::OFS_DATA, 32'h00A5);
		rd(syn_pkg::OFS_RAW, 32'h8, 32'h8);
		w0 = words;
		wr(syn_pkg::OFS_CR1, 32'h2);
		rd(syn_pkg::OFS_RAW, 32'h0, 32'h8);
		$display("test disable done");
		// other format, 8-bit words: frame idles low and pulses high before each word
		wait_words(w0 + 8'h6);
		wr(syn_pkg::OFS_CR1, 32'h0);
		wr(syn_pkg::OFS_CR0, 32'h0117);
		tx_w[0] = 16'($random(seed));
		wr(syn_pkg::OFS_DATA, {16'h0, tx_w[0]});
		wr(syn_pkg::OFS_DATA, 32'h0000);
		chk("idle frame", 32'(frame), 32'h0);
		// unread data left idle long enough to time out, then a word start clears it
		repeat (270) @(posedge clk_i);
		rd(syn_pkg::OFS_RAW, 32'h2, 32'h2);
		w0 = words;
		wr(syn_pkg::OFS_CR1, 32'h2);
		wait_words(w0 + 8'h2);
		chk("short word", 32'(got), 32'({8'hA5, tx_w[0][7:0]}));
		rd(syn_pkg::OFS_RAW, 32'h0, 32'h2);
		$display("test frame format done");
		repeat (3) @(posedge clk_i);
		chk("pending reads", 32'(exp_q.size()), 32'h0);
		close_out();
	end
endmodule
